// ---- hdl/gcs_params.svh ----
// Constants of the global chop sequencer: offsets, fields, resets, counts.
// Assumes inclusion by bare name from the design files.
//
// What this block does
// - With chop on, two internal conversions make every output result.
// - First conversion of a pair normal polarity, second with inputs swapped.
// - Output is the average of both polarities, cancelling the input offset.
// - Chop enable is one bit of the rate register at offset 04h.
// - Low-latency filter settles in one conversion; chop first output ~two.
// - Sinc3 filter settles in three conversions; chopped first output ~six.
// - Continuous chopped results after the first take one conversion: half the first's time (LL), a sixth (sinc3).
// - Continuous chop pipelines polarities; each new one averages previous.
// - Low-latency 2.5 SPS chop: first 208130, later 104065 modulator periods.
// - Line-cycle rejection only at data rates of 60 SPS or slower.
// - Conversion starts on trigger pin rising edge or a start command.
// - Programmable delay, default 14 periods, before first conversion only.
// - Sinc3 suppresses its first two unsettled outputs from the host.
`ifndef GCS_PARAMS_SVH
`define GCS_PARAMS_SVH

// ***********************************
// Register offsets
// ***********************************
`define GCS_ADR_CTRL    8'h00
`define GCS_ADR_RATE    8'h04
`define GCS_ADR_DLY     8'h08
`define GCS_ADR_STAT    8'h0C
`define GCS_ADR_RES     8'h10

// ***********************************
// Field positions
// ***********************************
`define GCS_CTRL_CONT   0
`define GCS_CTRL_START  1
`define GCS_CTRL_STOP   2
`define GCS_RATE_CHOP   5
`define GCS_RATE_LL     4
`define GCS_STAT_BUSY   0
`define GCS_STAT_RDY    1
`define GCS_STAT_SWAP   2
`define GCS_STAT_LREJ   3

// ***********************************
// Reset values
// ***********************************
`define GCS_RATE_RST    8'h14
`define GCS_DLY_RST     8'h0E

// ***********************************
// Timing counts
// ***********************************
`define GCS_MOD_DIV     16
`define GCS_SETTLE_LL   2'h1
`define GCS_SETTLE_S3   2'h3
`define GCS_RATE_LAST   4'hD
`define GCS_LREJ_MAX    4'h6
`define GCS_PER_S3 '{102400, 51200, 25600, 15360, 12800, 5120, 4264, \
  2560, 1280, 640, 320, 256, 128, 64}
`define GCS_PER_LL '{104065, 52865, 25600, 15360, 12800, 5120, 4264, \
  2560, 1280, 640, 320, 256, 128, 64}

`endif

// ---- hdl/gcs_pkg.sv ----
// Types of the global chop sequencer.
// Assumes nothing of its surroundings.
package gcs_pkg;

  // ***********************************
  // Sequencer states
  // ***********************************
  typedef enum logic [2:0] {
    GCS_IDLE  = 3'h1,
    GCS_DELAY = 3'h2,
    GCS_CONV  = 3'h4
  } gcs_state_t;

endpackage

// ---- hdl/gcs_tmod_timer.sv ----
// Down counter of modulator periods for one timed interval.
// Assumes a one-cycle tick per modulator period from the parent.
`timescale 1ns/1ns
module gcs_tmod_timer #(
  parameter int W = 18
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Control
  input  wire logic         load_i,
  input  wire logic [W-1:0] len_i,
  input  wire logic         tick_i,
  // Status
  output logic              done_o
);

  logic [W-1:0] cnt_r;
  wire          last;

  assign last   = (cnt_r == W'(1));
  assign done_o = tick_i & last;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (load_i) begin
      cnt_r <= len_i;
    end else if (tick_i && cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

endmodule

// ---- hdl/gcs_top.sv ----
// Global chop conversion sequencer with a classic Wishbone register slave.
// Assumes clk_i is the master clock; filt_data_i holds the filter's
// output for the conversion that is ending whenever a conversion ends.
`timescale 1ns/1ns
`include "gcs_params.svh"
module gcs_top #(
  parameter int          DW      = 16,
  parameter int          MOD_DIV = `GCS_MOD_DIV,
  parameter int unsigned PER_S3 [14] = `GCS_PER_S3,
  parameter int unsigned PER_LL [14] = `GCS_PER_LL
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Wishbone slave
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [31:0]   wb_dat_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic          wb_we_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // Converter side
  input  wire logic          conv_trig_i,
  input  wire logic [DW-1:0] filt_data_i,
  output logic               mod_run_o,
  output logic               chop_swap_o,
  output logic               drdy_n_o,
  output logic               line_rej_o
);

  localparam int TW = 18;
  // A literal cannot be indexed, so the reset word gets a name
  localparam logic [7:0] RATE_RST = `GCS_RATE_RST;

  // ***********************************
  // Bus decode
  // ***********************************
  logic ack_r;
  wire  req;
  wire  wr;
  wire  rd;
  wire  wr0;
  wire  sel_ctrl;
  wire  sel_rate;
  wire  sel_dly;
  wire  sel_stat;
  wire  sel_res;

  assign req      = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr       = req & wb_we_i;
  assign rd       = req & ~wb_we_i;
  assign wr0      = wr & wb_sel_i[0];
  assign sel_ctrl = (wb_adr_i == `GCS_ADR_CTRL);
  assign sel_rate = (wb_adr_i == `GCS_ADR_RATE);
  assign sel_dly  = (wb_adr_i == `GCS_ADR_DLY);
  assign sel_stat = (wb_adr_i == `GCS_ADR_STAT);
  assign sel_res  = (wb_adr_i == `GCS_ADR_RES);

  // ***********************************
  // Configuration
  // ***********************************
  logic       cont_r;
  logic       chop_r;
  logic       ll_r;
  logic [3:0] rate_r;
  logic [7:0] dly_r;
  wire        wr_rate;
  wire        start_cmd;
  wire        stop_cmd;

  assign wr_rate   = wr0 & sel_rate;
  assign start_cmd = wr0 & sel_ctrl & wb_dat_i[`GCS_CTRL_START];
  assign stop_cmd  = wr0 & sel_ctrl & wb_dat_i[`GCS_CTRL_STOP];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cont_r <= 1'b0;
      chop_r <= RATE_RST[`GCS_RATE_CHOP];
      ll_r   <= RATE_RST[`GCS_RATE_LL];
      rate_r <= RATE_RST[3:0];
      dly_r  <= `GCS_DLY_RST;
    end else begin
      if (wr0 && sel_ctrl) begin
        cont_r <= wb_dat_i[`GCS_CTRL_CONT];
      end
      if (wr_rate) begin
        chop_r <= wb_dat_i[`GCS_RATE_CHOP];
        ll_r   <= wb_dat_i[`GCS_RATE_LL];
        rate_r <= wb_dat_i[3:0];
      end
      if (wr0 && sel_dly) begin
        dly_r <= wb_dat_i[7:0];
      end
    end
  end

  // ***********************************
  // Start sources
  // ***********************************
  logic trig_q;
  wire  trig_rise;
  wire  go;

  assign trig_rise = conv_trig_i & ~trig_q;
  assign go        = trig_rise | start_cmd;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= conv_trig_i;
    end
  end

  // ***********************************
  // Modulator period prescaler
  // ***********************************
  gcs_pkg::gcs_state_t st_r;
  gcs_pkg::gcs_state_t st_nxt;
  logic [7:0]          pre_r;
  wire                 tick;
  wire                 idle;

  assign idle = (st_r == gcs_pkg::GCS_IDLE);
  assign tick = ~idle & (pre_r == 8'(MOD_DIV - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || idle || tick) begin
      pre_r <= 8'h00;
    end else begin
      pre_r <= pre_r + 8'h01;
    end
  end

  // ***********************************
  // Interval timing
  // ***********************************
  wire [3:0]    rate_idx;
  wire [TW-1:0] per_len;
  wire [TW-1:0] load_len;
  wire          load;
  wire          done;
  wire          in_dly;
  wire          in_conv;
  wire          conv_end;
  wire          stop_now;
  wire          use_dly;
  wire          pub;

  assign rate_idx = (rate_r > `GCS_RATE_LAST) ? `GCS_RATE_LAST : rate_r;
  assign per_len  = ll_r ? TW'(PER_LL[rate_idx]) : TW'(PER_S3[rate_idx]);
  assign in_dly   = (st_r == gcs_pkg::GCS_DELAY);
  assign in_conv  = (st_r == gcs_pkg::GCS_CONV);
  assign conv_end = in_conv & done;
  assign stop_now = stop_cmd & ~idle;
  assign use_dly  = idle & go & (dly_r != 8'h00);
  assign load_len = use_dly ? TW'(dly_r) : per_len;
  // Pairs and settling need a reload in single shot too
  assign load     = (idle & go) | (in_dly & done) |
                    (conv_end & (cont_r | ~pub));

  gcs_tmod_timer #(
    .W      (TW)
  ) u_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .load_i (load),
    .len_i  (load_len),
    .tick_i (tick),
    .done_o (done)
  );

  // ***********************************
  // Sequencer state
  // ***********************************
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      gcs_pkg::GCS_IDLE: begin
        if (go) begin
          st_nxt = use_dly ? gcs_pkg::GCS_DELAY : gcs_pkg::GCS_CONV;
        end
      end
      gcs_pkg::GCS_DELAY: begin
        if (done) begin
          st_nxt = gcs_pkg::GCS_CONV;
        end
      end
      gcs_pkg::GCS_CONV: begin
        if (pub && !cont_r) begin
          st_nxt = gcs_pkg::GCS_IDLE;
        end
      end
      default: begin
        st_nxt = gcs_pkg::GCS_IDLE;
      end
    endcase
    if (stop_now) begin
      st_nxt = gcs_pkg::GCS_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= gcs_pkg::GCS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***********************************
  // Chop pairing and averaging
  // ***********************************
  logic [1:0]    cnt_r;
  logic          swap_r;
  logic          first_r;
  logic [DW-1:0] norm_r;
  logic [DW-1:0] rev_r;
  logic [DW-1:0] res_r;
  wire  [1:0]    settle;
  wire           settled;
  wire  [DW:0]   diff_a;
  wire  [DW:0]   diff_b;
  wire  [DW-1:0] res_nxt;

  assign settle  = ll_r ? `GCS_SETTLE_LL : `GCS_SETTLE_S3;
  assign settled = (cnt_r + 2'h1 == settle);
  assign pub     = conv_end & (~first_r | (settled & (~chop_r | swap_r)));
  // offset cancels in half difference
  // Reversed sample carries -Vin, so half the difference is the average
  assign diff_a  = {norm_r[DW-1], norm_r} - {filt_data_i[DW-1], filt_data_i};
  assign diff_b  = {filt_data_i[DW-1], filt_data_i} - {rev_r[DW-1], rev_r};
  assign res_nxt = !chop_r ? filt_data_i :
                   swap_r  ? diff_a[DW:1] : diff_b[DW:1];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r   <= 2'h0;
      swap_r  <= 1'b0;
      first_r <= 1'b1;
      norm_r  <= '0;
      rev_r   <= '0;
      res_r   <= '0;
    end else if (idle) begin
      cnt_r   <= 2'h0;
      swap_r  <= 1'b0;
      first_r <= 1'b1;
    end else if (conv_end) begin
      cnt_r <= (first_r && !settled) ? cnt_r + 2'h1 : 2'h0;
      if (chop_r && (settled || !first_r)) begin
        swap_r <= ~swap_r;
        if (swap_r) begin
          rev_r <= filt_data_i;
        end else begin
          norm_r <= filt_data_i;
        end
      end
      if (pub) begin
        res_r   <= res_nxt;
        first_r <= 1'b0;
      end
    end
  end

  // ***********************************
  // Data ready flag
  // ***********************************
  logic rdy_r;
  wire  rd_res;

  assign rd_res = rd & sel_res;

  // A result landing on the read that clears the flag keeps it set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_r <= 1'b0;
    end else if (pub) begin
      rdy_r <= 1'b1;
    end else if (rd_res || (idle && go)) begin
      rdy_r <= 1'b0;
    end
  end

  // ***********************************
  // Read mux and bus answer
  // ***********************************
  wire [31:0] rd_data;
  wire [7:0]  stat_v;
  wire        lrej;

  assign lrej    = (rate_r <= `GCS_LREJ_MAX);
  assign stat_v  = {4'h0, lrej, swap_r, rdy_r, ~idle};
  assign rd_data = sel_ctrl ? {31'h0, cont_r} :
                   sel_rate ? {26'h0, chop_r, ll_r, rate_r} :
                   sel_dly  ? {24'h0, dly_r} :
                   sel_stat ? {24'h0, stat_v} :
                   sel_res  ? {{(32 - DW){1'b0}}, res_r} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_r    <= req;
      wb_dat_o <= rd ? rd_data : 32'h0;
    end
  end

  assign wb_ack_o = ack_r;

  // ***********************************
  // Converter side outputs
  // ***********************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_run_o   <= 1'b0;
      chop_swap_o <= 1'b0;
      drdy_n_o    <= 1'b1;
      line_rej_o  <= 1'b0;
    end else begin
      mod_run_o   <= (st_nxt == gcs_pkg::GCS_CONV);
      chop_swap_o <= swap_r;
      drdy_n_o    <= ~rdy_r;
      line_rej_o  <= lrej;
    end
  end

endmodule

// ---- test/gcs_front_model.sv ----
// Front-end stand-in: filter output of a fixed input plus offset.
// Assumes swap_i is the polarity of the conversion in progress.
`timescale 1ns/1ns
module gcs_front_model #(
  parameter int          DW  = 16,
  parameter logic [15:0] SIG = 16'h0123,
  parameter logic [15:0] OFS = 16'h0040
) (
  input  wire logic          swap_i,
  output logic      [DW-1:0] filt_data_o
);
  // swap flips signal only
  // Offset keeps its sign, so only a true average cancels it
  assign filt_data_o = swap_i ? DW'(OFS - SIG) : DW'(SIG + OFS);
endmodule

// ---- test/gcs_top_monitor.sv ----
// Port checker for the global chop sequencer.
// Assumes it is bound to gcs_top and sees only its ports.
`timescale 1ns/1ns
module gcs_top_monitor #(
  parameter int DW      = 16,
  parameter int MOD_DIV = 16
) (
  // Clock and reset
  input wire logic          clk_i,
  input wire logic          rst_i,
  // Wishbone
  input wire logic [7:0]    wb_adr_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic          wb_we_i,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  // Converter side
  input wire logic          conv_trig_i,
  input wire logic [DW-1:0] filt_data_i,
  input wire logic          mod_run_o,
  input wire logic          chop_swap_o,
  input wire logic          drdy_n_o,
  input wire logic          line_rej_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Start delay of zero, tracked at the edge the write is taken
  logic dly_zero_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly_zero_r <= 1'b0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
                 wb_sel_i[0] && wb_adr_i == 8'h08) begin
      dly_zero_r <= (wb_dat_i[7:0] == 8'h00);
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_run2;
    mod_run_o [*2];
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside answer");
  a_rst_vals: assert property ($fell(rst_i) |-> !mod_run_o &&
    drdy_n_o && !chop_swap_o && !wb_ack_o)
    else $error("outputs not at reset level");
  a_run_min: assert property ($rose(mod_run_o) |-> s_run2)
    else $error("conversion too short");
  a_trig_delay: assert property (
    $rose(conv_trig_i) && !mod_run_o && !dly_zero_r |=> !mod_run_o)
    else $error("conversion skipped start delay");
  a_drdy_hold: assert property (
    $fell(drdy_n_o) && !wb_stb_i |=> !drdy_n_o)
    else $error("data ready dropped unread");
  a_lrej_write: assert property ($changed(line_rej_o) |->
    $past(wb_we_i && wb_stb_i, 2) || $past(rst_i, 2) || $past(rst_i, 3))
    else $error("line rejection changed without write");
  a_swap_run: assert property ($rose(chop_swap_o) |-> $past(mod_run_o))
    else $error("polarity swapped outside conversion");
endmodule
bind gcs_top gcs_top_monitor #(.DW(DW), .MOD_DIV(MOD_DIV)) i_gcs_top_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .conv_trig_i(conv_trig_i),
  .mod_run_o(mod_run_o), .chop_swap_o(chop_swap_o), .drdy_n_o(drdy_n_o),
  .line_rej_o(line_rej_o), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .filt_data_i(filt_data_i));

// ---- test/tb_top.sv ----
// Testbench of the global chop sequencer over classic Wishbone.
// Assumes shortened periods: MOD_DIV 2, every conversion 4 periods.
`timescale 1ns/1ns
module tb_top;
  localparam int          MD = 2;
  localparam int unsigned PER [14] = '{default: 4};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic        we    = 1'b0;
  logic        stb   = 1'b0;
  logic        trig  = 1'b0;
  logic [31:0] rdo, rdat;
  logic [15:0] fdat;
  logic        ack, run, swap, drdy_n, lrej;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          dly = 14;
  int          c;
  always #50 clk_i = ~clk_i;
  gcs_top #(.MOD_DIV(MD), .PER_S3(PER), .PER_LL(PER)) i_gcs_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'h1), .wb_we_i(we), .wb_cyc_i(stb), .wb_stb_i(stb),
    .wb_dat_o(rdo), .wb_ack_o(ack), .conv_trig_i(trig),
    .filt_data_i(fdat), .mod_run_o(run), .chop_swap_o(swap),
    .drdy_n_o(drdy_n), .line_rej_o(lrej));
  gcs_front_model i_gcs_front_model (.swap_i(swap), .filt_data_o(fdat));
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    adr <= a;
    we <= w;
    wdat <= {24'h0, d};
    stb <= 1'b1;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) begin
      fail_count++;
      $display("mismatch at %0t: no bus answer", $time);
    end
    rdat = rdo;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  // Start by command or, with ctl zero, by the trigger pin
  task automatic conv(input logic [7:0] rate, input logic [7:0] ctl,
                      input logic [15:0] exp, input int nconv);
    bus(8'h04, 1'b1, rate);
    if (ctl == 8'h00) begin
      trig <= 1'b1;
      @(posedge clk_i);
      trig <= 1'b0;
    end else
      bus(8'h00, 1'b1, ctl);
    c = 0;
    while (drdy_n !== 1'b0 && c < 500) begin
      @(posedge clk_i);
      c++;
    end
    chk({31'h0, c >= dly * MD + 8 * nconv - 4}, 32'h1);
    chk({31'h0, c <= dly * MD + 8 * nconv + 4}, 32'h1);
    bus(8'h10, 1'b0, 8'h00);
    chk(rdat, {16'h0, exp});
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    bus(8'h04, 1'b0, 8'h00);
    chk(rdat, 32'h14);
    bus(8'h08, 1'b0, 8'h00);
    chk(rdat, 32'h0E);
    bus(8'h20, 1'b0, 8'h00);
    chk(rdat, 32'h0);
    for (int i = 0; i < 14; i++) begin
      bus(8'h04, 1'b1, 8'h10 + 8'(i));
      chk({31'h0, lrej}, {31'h0, i <= 6});
    end
    conv(8'h14, 8'h02, 16'h0163, 1);
    conv(8'h34, 8'h02, 16'h0123, 2);
    conv(8'h24, 8'h00, 16'h0123, 6);
    conv(8'h04, 8'h02, 16'h0163, 3);
    conv(8'h34, 8'h03, 16'h0123, 2);
    c = 0;
    while (drdy_n !== 1'b0 && c < 50) begin
      @(posedge clk_i);
      c++;
    end
    // Later result comes in one conversion, with no start delay
    chk({31'h0, c <= 8}, 32'h1);
    chk({31'h0, swap}, 32'h1);
    bus(8'h10, 1'b0, 8'h00);
    chk(rdat, 32'h0123);
    bus(8'h00, 1'b1, 8'h04);
    chk({31'h0, run}, 32'h0);
    bus(8'h08, 1'b1, 8'h00);
    dly = 0;
    conv(8'h14, 8'h02, 16'h0163, 1);
    stop_test;
  end
  initial begin
    #300000;
    fail_count++;
    stop_test;
  end
endmodule
